// *** rtl/mtc_pkg.sv ***
package mtc_pkg;
    localparam int MTC_ADDR_W = 11;
    localparam int MTC_DATA_W = 32;
    localparam int MTC_GAP_W = 8;
    localparam logic [10:0] MTC_OFF_TXC = 11'h408;
    localparam logic [10:0] MTC_OFF_FCC = 11'h40C;
    // Transmitter configuration field positions.
    localparam int MTC_TXC_RST = 31;
    localparam int MTC_TXC_JUMBO = 30;
    localparam int MTC_TXC_FCS = 29;
    localparam int MTC_TXC_EN = 28;
    localparam int MTC_TXC_VLAN = 27;
    localparam int MTC_TXC_WAN = 26;
    localparam int MTC_TXC_IFG = 25;
    localparam int MTC_TXC_DIC = 24;
    localparam int MTC_TXC_PRE = 23;
    // Flow control field positions.
    localparam int MTC_FCC_TX = 30;
    localparam int MTC_FCC_RX = 29;
    // Reset values and the bits that are stored.
    localparam logic [31:0] MTC_TXC_DEF = 32'h1000_0000;
    localparam logic [31:0] MTC_FCC_DEF = 32'h6000_0000;
    localparam logic [31:0] MTC_TXC_MASK = 32'h7F80_0000;
    localparam logic [31:0] MTC_FCC_MASK = 32'h6000_0000;
    localparam logic [31:0] MTC_ZERO = 32'h0000_0000;
    localparam logic [7:0] MTC_GAP_ZERO = 8'h00;
endpackage

// *** rtl/mtc_tx_config.sv ***
`timescale 1ns/1ps
module mtc_tx_config (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Management interface
    input wire logic [mtc_pkg::MTC_ADDR_W-1:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [mtc_pkg::MTC_DATA_W-1:0] mgmt_wdata,
    output logic [mtc_pkg::MTC_DATA_W-1:0] mgmt_rdata,
    output logic mgmt_rd_valid,
    // Transmit datapath status
    input wire logic tx_in_gap,
    input wire logic tx_frame_start,
    input wire logic [mtc_pkg::MTC_GAP_W-1:0] tx_ifg_delay,
    // Flow control events
    input wire logic pause_req,
    input wire logic rx_pause_rcvd,
    // Settings towards the datapath
    output logic tx_soft_reset,
    output logic tx_jumbo_en,
    output logic tx_fcs_inband,
    output logic tx_pad_fcs_gen,
    output logic tx_enable,
    output logic tx_vlan_en,
    output logic tx_wan_mode,
    output logic tx_ifg_adjust,
    output logic tx_dic_en,
    output logic tx_preamble_keep,
    output logic [mtc_pkg::MTC_GAP_W-1:0] tx_ifg_extra,
    // Flow control actions
    output logic pause_send,
    output logic tx_pause_hold,
    output logic rx_pause_forward
);
    import mtc_pkg::*;

    typedef struct packed {
        logic [31:0] txc_stage;
        logic [31:0] fcc_stage;
        logic [31:0] txc_live;
        logic [31:0] fcc_live;
        logic [31:0] rdata;
        logic rd_valid;
        logic soft_rst;
        logic [7:0] gap_extra;
        logic pause_send;
        logic hold;
        logic forward;
    } mtc_state_t;

    mtc_state_t state_reg;
    mtc_state_t state_next;

    function automatic logic mtc_hit(input logic [10:0] a,
                                     input logic [10:0] off);
        mtc_hit = (a == off);
    endfunction

    logic wr_txc;
    logic wr_fcc;
    logic soft_req;
    logic adj_live;
    logic [31:0] txc_wval;

    assign wr_txc = mgmt_wr && mtc_hit(mgmt_addr, MTC_OFF_TXC);
    assign wr_fcc = mgmt_wr && mtc_hit(mgmt_addr, MTC_OFF_FCC);
    assign soft_req = wr_txc && mgmt_wdata[MTC_TXC_RST];
    // WAN mode masks the gap adjust request.
    assign adj_live = state_reg.txc_live[MTC_TXC_IFG]
                      && !state_reg.txc_live[MTC_TXC_WAN];

    always_comb begin
        txc_wval = mgmt_wdata & MTC_TXC_MASK;
        // The deficit idle bit cannot be stored while gap adjust is set.
        if (txc_wval[MTC_TXC_IFG]) begin
            txc_wval[MTC_TXC_DIC] = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.soft_rst = 1'b0;
        state_next.rd_valid = mgmt_rd;
        if (wr_fcc) begin
            state_next.fcc_stage = mgmt_wdata & MTC_FCC_MASK;
        end
        if (wr_txc) begin
            state_next.txc_stage = txc_wval;
        end
        // Written settings move to the live copy only between frames, so apart from
        // a soft reset a frame in flight never sees its framing rules change halfway.
        if (tx_in_gap) begin
            state_next.txc_live = state_next.txc_stage;
            state_next.fcc_live = state_next.fcc_stage;
        end
        // Soft reset bypasses the gap wait and restores the transmitter defaults.
        if (soft_req) begin
            state_next.txc_stage = MTC_TXC_DEF;
            state_next.txc_live = MTC_TXC_DEF;
            state_next.soft_rst = 1'b1;
        end
        if (mgmt_rd) begin
            if (mtc_hit(mgmt_addr, MTC_OFF_TXC)) begin
                state_next.rdata = state_reg.txc_stage;
            end else if (mtc_hit(mgmt_addr, MTC_OFF_FCC)) begin
                state_next.rdata = state_reg.fcc_stage;
            end else begin
                state_next.rdata = MTC_ZERO;
            end
        end
        if (tx_frame_start) begin
            state_next.gap_extra = adj_live ? tx_ifg_delay
                                            : MTC_GAP_ZERO;
        end
        if (!adj_live) begin
            state_next.gap_extra = MTC_GAP_ZERO;
        end
        state_next.pause_send = pause_req
                                && state_reg.fcc_live[MTC_FCC_TX];
        state_next.hold = rx_pause_rcvd
                          && state_reg.fcc_live[MTC_FCC_RX];
        state_next.forward = rx_pause_rcvd
                             && !state_reg.fcc_live[MTC_FCC_RX];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{txc_stage: MTC_TXC_DEF, fcc_stage: MTC_FCC_DEF,
                           txc_live: MTC_TXC_DEF, fcc_live: MTC_FCC_DEF,
                           rdata: MTC_ZERO, rd_valid: 1'b0,
                           soft_rst: 1'b0, gap_extra: MTC_GAP_ZERO,
                           pause_send: 1'b0, hold: 1'b0, forward: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign mgmt_rdata = state_reg.rdata;
    assign mgmt_rd_valid = state_reg.rd_valid;
    assign tx_soft_reset = state_reg.soft_rst;
    assign tx_jumbo_en = state_reg.txc_live[MTC_TXC_JUMBO];
    assign tx_fcs_inband = state_reg.txc_live[MTC_TXC_FCS];
    assign tx_pad_fcs_gen = !state_reg.txc_live[MTC_TXC_FCS];
    assign tx_enable = state_reg.txc_live[MTC_TXC_EN];
    assign tx_vlan_en = state_reg.txc_live[MTC_TXC_VLAN];
    assign tx_wan_mode = state_reg.txc_live[MTC_TXC_WAN];
    assign tx_ifg_adjust = adj_live;
    assign tx_dic_en = state_reg.txc_live[MTC_TXC_DIC];
    assign tx_preamble_keep = state_reg.txc_live[MTC_TXC_PRE];
    assign tx_ifg_extra = state_reg.gap_extra;
    assign pause_send = state_reg.pause_send;
    assign tx_pause_hold = state_reg.hold;
    assign rx_pause_forward = state_reg.forward;

    a_soft_reset_defaults: assert property (
        @(posedge ref_clk) disable iff (rst)
        soft_req |=> tx_soft_reset && tx_enable && !tx_jumbo_en
                     && state_reg.txc_stage == MTC_TXC_DEF)
        else $error("Soft reset did not restore defaults.");

    a_reset_bit_clears: assert property (
        @(posedge ref_clk) disable iff (rst)
        !state_reg.txc_stage[MTC_TXC_RST]
        && !state_reg.txc_live[MTC_TXC_RST])
        else $error("Transmitter reset bit stayed set.");

    a_fcs_pad_exclusive: assert property (
        @(posedge ref_clk) disable iff (rst)
        tx_pad_fcs_gen != tx_fcs_inband)
        else $error("Pad and inband FCS both set or both clear.");

    a_live_in_gap: assert property (
        @(posedge ref_clk) disable iff (rst)
        !tx_in_gap && !soft_req |=> $stable(state_reg.txc_live)
                                    && $stable(state_reg.fcc_live))
        else $error("Setting changed outside an interframe gap.");

    a_gap_apply: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_txc && !soft_req && tx_in_gap
        |=> state_reg.txc_live == $past(txc_wval))
        else $error("Write in gap did not take effect.");

    a_wan_masks_adj: assert property (
        @(posedge ref_clk) disable iff (rst)
        tx_wan_mode |-> !tx_ifg_adjust)
        else $error("Gap adjust active in WAN mode.");

    a_dic_forced_off: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(state_reg.txc_stage[MTC_TXC_IFG]
          && state_reg.txc_stage[MTC_TXC_DIC]))
        else $error("Deficit idle bit stored with gap adjust.");

    a_gap_sample: assert property (
        @(posedge ref_clk) disable iff (rst)
        tx_frame_start && adj_live ##1 adj_live
        |-> tx_ifg_extra == $past(tx_ifg_delay))
        else $error("Gap stretch value not sampled at frame start.");

    a_gap_minimum: assert property (
        @(posedge ref_clk) disable iff (rst)
        !adj_live |=> tx_ifg_extra == MTC_GAP_ZERO)
        else $error("Gap stretched while adjust is off.");

    a_pause_send: assert property (
        @(posedge ref_clk) disable iff (rst)
        pause_req |=> pause_send == $past(state_reg.fcc_live[MTC_FCC_TX]))
        else $error("Pause trigger not handled per enable.");

    a_pause_route: assert property (
        @(posedge ref_clk) disable iff (rst)
        rx_pause_rcvd |=> (tx_pause_hold ^ rx_pause_forward)
                          && tx_pause_hold
                             == $past(state_reg.fcc_live[MTC_FCC_RX]))
        else $error("Received pause frame misrouted.");

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        mgmt_rd_valid |-> (mgmt_rdata & ~(MTC_TXC_MASK | MTC_FCC_MASK))
                          == MTC_ZERO)
        else $error("Reserved bits read nonzero.");

    // Reads return the staged word, so software sees its own write at once
    // even while the live copy still waits for a gap.
    a_read_txc_word: assert property (
        @(posedge ref_clk) disable iff (rst)
        mgmt_rd && mtc_hit(mgmt_addr, MTC_OFF_TXC)
        |=> mgmt_rd_valid && mgmt_rdata == $past(state_reg.txc_stage))
        else $error("Transmit word read returned wrong data.");

    a_read_fcc_word: assert property (
        @(posedge ref_clk) disable iff (rst)
        mgmt_rd && mtc_hit(mgmt_addr, MTC_OFF_FCC)
        |=> mgmt_rd_valid && mgmt_rdata == $past(state_reg.fcc_stage))
        else $error("Flow control word read returned wrong data.");

    a_read_unmapped: assert property (
        @(posedge ref_clk) disable iff (rst)
        mgmt_rd && !mtc_hit(mgmt_addr, MTC_OFF_TXC)
        && !mtc_hit(mgmt_addr, MTC_OFF_FCC)
        |=> mgmt_rd_valid && mgmt_rdata == MTC_ZERO)
        else $error("Unmapped read returned nonzero data.");

    a_rd_valid_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        !mgmt_rd |=> !mgmt_rd_valid)
        else $error("Read valid raised without a read.");

    a_txc_write_stage: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_txc && !soft_req
        |=> state_reg.txc_stage[MTC_TXC_JUMBO:MTC_TXC_IFG]
            == $past(mgmt_wdata[MTC_TXC_JUMBO:MTC_TXC_IFG])
            && state_reg.txc_stage[MTC_TXC_PRE]
            == $past(mgmt_wdata[MTC_TXC_PRE]))
        else $error("Transmit word write not staged.");

    a_fcc_write_stage: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_fcc |=> state_reg.fcc_stage == ($past(mgmt_wdata) & MTC_FCC_MASK))
        else $error("Flow control write not staged.");

    // The soft reset belongs to the transmitter only; flow control survives.
    a_soft_keeps_flow: assert property (
        @(posedge ref_clk) disable iff (rst)
        soft_req |=> $stable(state_reg.fcc_stage))
        else $error("Soft reset disturbed the flow control word.");

    a_soft_self_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        !soft_req |=> !tx_soft_reset)
        else $error("Soft reset pulse without a request.");

    a_dic_live_off: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(state_reg.txc_live[MTC_TXC_IFG] && tx_dic_en))
        else $error("Deficit idle active with gap adjust.");

    a_send_needs_req: assert property (
        @(posedge ref_clk) disable iff (rst)
        pause_send |-> $past(pause_req))
        else $error("Pause frame sent without a trigger.");

    a_hold_needs_rx: assert property (
        @(posedge ref_clk) disable iff (rst)
        tx_pause_hold |-> $past(rx_pause_rcvd)
                          && $past(state_reg.fcc_live[MTC_FCC_RX]))
        else $error("Transmit held without an accepted pause.");

    a_forward_needs_rx: assert property (
        @(posedge ref_clk) disable iff (rst)
        rx_pause_forward |-> $past(rx_pause_rcvd)
                             && !$past(state_reg.fcc_live[MTC_FCC_RX]))
        else $error("Pause forwarded while receive control enabled.");

    // Between frame starts the stretch value must stand still, or the
    // datapath would see a gap length that no client ever asked for.
    a_extra_holds: assert property (
        @(posedge ref_clk) disable iff (rst)
        !tx_frame_start && adj_live |=> $stable(tx_ifg_extra))
        else $error("Gap stretch value changed without a frame start.");
endmodule

// *** testbench/mtc_dp_model.sv ***
`timescale 1ns/1ps
module mtc_dp_model (
    // Clock, reset and bench control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    // Datapath status towards the block
    output logic tx_in_gap,
    output logic tx_frame_start,
    output logic [mtc_pkg::MTC_GAP_W-1:0] tx_ifg_delay
);
    import mtc_pkg::*;
    logic [3:0] cnt;
    // The stretch value moves every cycle, so a late sample shows up.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            tx_in_gap <= 1'b0;
            tx_frame_start <= 1'b0;
            tx_ifg_delay <= 8'h00;
        end else begin
            tx_ifg_delay <= tx_ifg_delay + 8'h25;
            tx_in_gap <= !stall && cnt[3] && cnt != 4'hF;
            // Frames start every sixteen cycles and last nine, far inside the WAN jumbo limit.
            tx_frame_start <= !stall && cnt == 4'hF;
            if (!stall) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// *** testbench/tb_mac_tx_and_pause_config.sv ***
`timescale 1ns/1ps
module tb_mac_tx_and_pause_config;
    import mtc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic stall = 1'b1;
    logic mgmt_wr = 1'b0;
    logic mgmt_rd = 1'b0;
    logic pause_req = 1'b0;
    logic rx_pause_rcvd = 1'b0;
    logic [10:0] mgmt_addr = 11'h000;
    logic [31:0] mgmt_wdata = 32'h0000_0000;
    logic [31:0] mgmt_rdata, w, f, got, prev;
    logic [7:0] tx_ifg_delay, tx_ifg_extra, dly;
    logic mgmt_rd_valid, tx_in_gap, tx_frame_start, tx_soft_reset;
    logic tx_jumbo_en, tx_fcs_inband, tx_pad_fcs_gen, tx_enable, tx_vlan_en;
    logic tx_wan_mode, tx_ifg_adjust, tx_dic_en, tx_preamble_keep;
    logic pause_send, tx_pause_hold, rx_pause_forward;
    logic [8:0] live;
    int failures = 0;
    int num_checks = 0;
    int seed = 31966;
    assign live = {tx_jumbo_en, tx_fcs_inband, tx_pad_fcs_gen, tx_enable,
        tx_vlan_en, tx_wan_mode, tx_ifg_adjust, tx_dic_en, tx_preamble_keep};
    always #2.5 ref_clk = ~ref_clk;
    mtc_dp_model model (.ref_clk, .rst, .stall, .tx_in_gap, .tx_frame_start,
        .tx_ifg_delay);
    mtc_tx_config dut (.ref_clk, .rst, .mgmt_addr, .mgmt_wr, .mgmt_rd,
        .mgmt_wdata, .mgmt_rdata, .mgmt_rd_valid, .tx_in_gap, .tx_frame_start,
        .tx_ifg_delay, .pause_req, .rx_pause_rcvd, .tx_soft_reset, .tx_jumbo_en,
        .tx_fcs_inband, .tx_pad_fcs_gen, .tx_enable, .tx_vlan_en, .tx_wan_mode,
        .tx_ifg_adjust, .tx_dic_en, .tx_preamble_keep, .tx_ifg_extra,
        .pause_send, .tx_pause_hold, .rx_pause_forward);
    function automatic logic [31:0] stored(input logic [31:0] d);
        logic [31:0] s;
        s = d & 32'h7F80_0000;
        if (s[25]) begin
            s[24] = 1'b0;
        end
        return s;
    endfunction
    function automatic logic [31:0] lv(input logic [31:0] s);
        return {23'h0, s[30], s[29], !s[29], s[28], s[27], s[26],
            s[25] && !s[26], s[24], s[23]};
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge ref_clk);
        mgmt_wr <= 1'b0;
    endtask
    task automatic rd(input logic [10:0] a);
        @(posedge ref_clk);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge ref_clk);
        mgmt_rd <= 1'b0;
        #1;
        got = mgmt_rdata;
        check({31'h0, mgmt_rd_valid}, 32'h0000_0001);
    endtask
    // Bounded wait for a gap, then one edge for the live copy to land.
    task automatic wait_gap;
        for (int k = 0; k < 40 && tx_in_gap !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(11'h408);
        check(got, 32'h1000_0000);
        check(32'(live), lv(32'h1000_0000));
        rd(11'h40C);
        check(got, 32'h6000_0000);
        rd(11'h410);
        check(got, 32'h0000_0000);
        $display("test reset_values done");
        prev = 32'h1000_0000;
        for (int i = 0; i < 8; i++) begin
            w = $random(seed) & 32'h7FFF_FFFF;
            w = (i == 0) ? 32'h7FFF_FFFF : (i == 1) ? 32'h0380_0000 : w;
            f = ($random(seed) & 32'h9FFF_FFFF) | {1'b0, 2'(i), 29'h0};
            stall <= 1'b1;
            repeat (2) @(posedge ref_clk);
            wr(11'h408, w);
            wr(11'h40C, f);
            rd(11'h408);
            check(got, stored(w));
            rd(11'h40C);
            check(got, f & 32'h6000_0000);
            check(32'(live), lv(prev));
            stall <= 1'b0;
            wait_gap;
            prev = stored(w);
            check(32'(live), lv(prev));
            for (int k = 0; k < 40 && tx_frame_start !== 1'b1; k++) begin
                @(posedge ref_clk);
                #1;
            end
            dly = tx_ifg_delay;
            @(posedge ref_clk);
            #1;
            check(32'(tx_ifg_extra), prev[25] && !prev[26] ? 32'(dly) : 0);
            @(posedge ref_clk);
            pause_req <= 1'b1;
            rx_pause_rcvd <= 1'b1;
            @(posedge ref_clk);
            pause_req <= 1'b0;
            rx_pause_rcvd <= 1'b0;
            #1;
            check({pause_send, tx_pause_hold, rx_pause_forward},
                {f[30], f[29], !f[29]});
            $display("test config_pass %0d done", i);
        end
        stall <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wr(11'h408, 32'hFFFF_FFFF);
        #1;
        check({31'h0, tx_soft_reset}, 32'h0000_0001);
        check(32'(live), lv(32'h1000_0000));
        rd(11'h408);
        check(got, 32'h1000_0000);
        rd(11'h40C);
        check(got, f & 32'h6000_0000);
        $display("test soft_reset done");
        print_verdict;
    end
endmodule
